// ==== hdl/ssc_pkg.sv ====
// Purpose: shared constants and types for the spread clock control block
// Assumes: AXI4-Lite register access, 40 MHz system clock
// Notes:   register byte address is four times the register index
package ssc_pkg;

  // ==========================================================
  // register map (indices; byte address = index * 4)
  // ==========================================================
  localparam logic [5:0] IDX_LOOP_CTRL2   = 6'h19;
  localparam logic [5:0] IDX_SPREAD_CTRL1 = 6'h1a;
  localparam logic [5:0] IDX_SPREAD_CMD   = 6'h1b;
  localparam logic [5:0] IDX_SPREAD_STAT  = 6'h1d;

  localparam logic [7:0] LOOP_CTRL2_RST   = 8'h18;
  localparam logic [7:0] SPREAD_CTRL1_RST = 8'h00;
  localparam logic [7:0] LOOP_CTRL2_MASK  = 8'h1f;
  localparam int         CMD_LOAD_BIT     = 7;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // ==========================================================
  // field layouts
  // ==========================================================
  typedef struct packed {
    logic [1:0] rate;
    logic       boost;
    logic       gain;
    logic [1:0] width;
    logic       sync;
    logic       enable;
  } ssc_cfg_t;

  typedef struct packed {
    logic [2:0] reserved;
    logic [1:0] pump;
    logic [2:0] filter;
  } ssc_loop_t;

  localparam logic [1:0] RATE_1X = 2'b00;
  localparam logic [1:0] RATE_2X = 2'b01;
  localparam logic [1:0] RATE_4X = 2'b10;

  // peak offset per width code, in 1/56 divide units
  localparam logic [7:0] AMP_W0 = 8'h10;
  localparam logic [7:0] AMP_W1 = 8'h08;
  localparam logic [7:0] AMP_W2 = 8'h04;
  localparam logic [7:0] AMP_W3 = 8'h02;

  localparam logic [7:0] STEP_NORMAL = 8'h02;
  localparam logic [7:0] STEP_BOOST  = 8'h01;

  // ==========================================================
  // timing
  // ==========================================================
  localparam int CLK_PERIOD_NS = 25;
  localparam int MOD_STEP_NS   = 1600;
  localparam int MOD_STEP_CYC  = MOD_STEP_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    SSC_IDLE,
    SSC_WAIT_SYNC,
    SSC_RUN
  } ssc_state_t;

endpackage

// ==== hdl/ssc_spread_ctrl.sv ====
// Purpose: spread modulator control with AXI4-Lite registers
// Assumes: line sync pulse arrives from a pin, asynchronous to sys_clk
// Notes:   divide offset output is signed, in 1/56 divide units
//
// What this block does
// [RQ1] rate field bits 7:6 scales modulation rate 1x, 2x, 4x; 11 reserved
// [RQ2] software keeps line length at most 32,768 when 4x is chosen
// [RQ3] boost clear steps the divide ratio by 1/28
// [RQ4] boost set steps the divide ratio by 1/56; peak spread stays set by width and gain
// [RQ5] software keeps pixel rate at most 25 MHz with boost set
// [RQ6] width bits 3:2 choose 5, 2.5, 1.25 or 0.625 percent total
// [RQ7] gain bit 4 doubles every selected width
// [RQ8] bit 0 enables spread; sync clear starts modulation at once
// [RQ9] sync set holds modulation until next line sync pulse
// [RQ10] software sets charge pump field to 00 before spreading
// [RQ11] software sets filter field to 111 when spreading
// [RQ12] enable rising edge reloads the state machine like load command
// [RQ13] settings changed while running apply only at next reload, except enable clear, which stops spreading at once
`timescale 1ns/100ps
module ssc_spread_ctrl (
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  input  wire logic [7:0] s_axi_awaddr,
  input  wire logic       s_axi_awvalid,
  output logic            s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0] s_axi_wstrb,
  input  wire logic       s_axi_wvalid,
  output logic            s_axi_wready,
  output logic [1:0]      s_axi_bresp,
  output logic            s_axi_bvalid,
  input  wire logic       s_axi_bready,
  input  wire logic [7:0] s_axi_araddr,
  input  wire logic       s_axi_arvalid,
  output logic            s_axi_arready,
  output logic [31:0]     s_axi_rdata,
  output logic [1:0]      s_axi_rresp,
  output logic            s_axi_rvalid,
  input  wire logic       s_axi_rready,
  input  wire logic       line_sync_interval,
  output logic [1:0]      loop_pump_current,
  output logic [2:0]      loop_filter_bw,
  output logic            spread_active,
  output logic [7:0]      div_offset
);

  // ==========================================================
  // helpers
  // ==========================================================
  function automatic logic hit(input logic [7:0] a, input logic [5:0] idx);
    return (a[1:0] == 2'b00) && (a[7:2] == idx);
  endfunction

  function automatic logic [7:0] width_amp(input logic [1:0] w,
                                           input logic       g);
    logic [7:0] a;
    case (w)
      2'b00:   a = ssc_pkg::AMP_W0;
      2'b01:   a = ssc_pkg::AMP_W1;
      2'b10:   a = ssc_pkg::AMP_W2;
      default: a = ssc_pkg::AMP_W3;
    endcase
    return g ? {a[6:0], 1'b0} : a;
  endfunction

  // ==========================================================
  // register bus
  // ==========================================================
  ssc_pkg::ssc_loop_t loop_reg;
  ssc_pkg::ssc_cfg_t  cfg;
  ssc_pkg::ssc_cfg_t  run_cfg;
  ssc_pkg::ssc_state_t state;
  logic [7:0] aw_addr;
  logic       aw_got;
  logic [7:0] w_data;
  logic       w_strb0;
  logic       w_got;
  logic       do_write;
  logic       load_req;
  logic       reload;

  assign s_axi_awready = !aw_got && !s_axi_bvalid;
  assign s_axi_wready  = !w_got && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign do_write      = aw_got && w_got && !s_axi_bvalid;

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      aw_got  <= 1'b0;
      aw_addr <= 8'h00;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_got  <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end
    else if (do_write)
      aw_got <= 1'b0;
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      w_got   <= 1'b0;
      w_data  <= 8'h00;
      w_strb0 <= 1'b0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_got   <= 1'b1;
      w_data  <= s_axi_wdata[7:0];
      w_strb0 <= s_axi_wstrb[0];
    end
    else if (do_write)
      w_got <= 1'b0;
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= ssc_pkg::RESP_OKAY;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
      if (hit(aw_addr, ssc_pkg::IDX_LOOP_CTRL2) ||
          hit(aw_addr, ssc_pkg::IDX_SPREAD_CTRL1) ||
          hit(aw_addr, ssc_pkg::IDX_SPREAD_CMD))
        s_axi_bresp <= ssc_pkg::RESP_OKAY;
      else
        s_axi_bresp <= ssc_pkg::RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // reserved bits 7:5 stay zero
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      loop_reg <= ssc_pkg::LOOP_CTRL2_RST;
      cfg      <= ssc_pkg::SPREAD_CTRL1_RST;
    end
    else if (do_write && w_strb0)
    begin
      if (hit(aw_addr, ssc_pkg::IDX_LOOP_CTRL2))
        loop_reg <= w_data & ssc_pkg::LOOP_CTRL2_MASK;
      if (hit(aw_addr, ssc_pkg::IDX_SPREAD_CTRL1))
        cfg <= w_data;
    end
  end

  // [RQ12] enable edge reload
  assign load_req = do_write && w_strb0 &&
    ((hit(aw_addr, ssc_pkg::IDX_SPREAD_CTRL1) && w_data[0] && !cfg.enable)
     || (hit(aw_addr, ssc_pkg::IDX_SPREAD_CMD) &&
         w_data[ssc_pkg::CMD_LOAD_BIT]));

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      reload <= 1'b0;
    else
      reload <= load_req;
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= ssc_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= ssc_pkg::RESP_OKAY;
      s_axi_rdata  <= 32'h0000_0000;
      if (hit(s_axi_araddr, ssc_pkg::IDX_LOOP_CTRL2))
        s_axi_rdata[7:0] <= loop_reg;
      else if (hit(s_axi_araddr, ssc_pkg::IDX_SPREAD_CTRL1))
        s_axi_rdata[7:0] <= cfg;
      else if (hit(s_axi_araddr, ssc_pkg::IDX_SPREAD_STAT))
        s_axi_rdata[15:0] <= {div_offset, 6'b00_0000,
                              state == ssc_pkg::SSC_WAIT_SYNC,
                              spread_active};
      else if (!hit(s_axi_araddr, ssc_pkg::IDX_SPREAD_CMD))
        s_axi_rresp <= ssc_pkg::RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // pump and filter are applied by software before spreading
  // [RQ10] pump field output
  assign loop_pump_current = loop_reg.pump;
  // [RQ11] filter field output
  assign loop_filter_bw = loop_reg.filter;

  // ==========================================================
  // line sync input
  // ==========================================================
  logic ls_meta;
  logic ls_sync;
  logic ls_last;
  logic ls_pulse;

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ls_meta <= 1'b0;
      ls_sync <= 1'b0;
      ls_last <= 1'b0;
    end
    else
    begin
      ls_meta <= line_sync_interval;
      ls_sync <= ls_meta;
      ls_last <= ls_sync;
    end
  end

  assign ls_pulse = ls_sync && !ls_last;

  // ==========================================================
  // modulation state
  // ==========================================================
  logic [5:0] tick_cnt;
  logic [5:0] tick_mask;
  logic       step_tick;
  logic [7:0] amp;
  logic [7:0] step;
  logic       dir_down;
  logic [7:0] next_offset;

  // [RQ13] shadow taken only at reload
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      run_cfg <= ssc_pkg::SPREAD_CTRL1_RST;
    else if (reload)
      run_cfg <= cfg;
  end

  // [RQ8] start or hold on enable
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      state <= ssc_pkg::SSC_IDLE;
    else if (!cfg.enable)
      state <= ssc_pkg::SSC_IDLE;
    else if (reload)
      state <= cfg.sync ? ssc_pkg::SSC_WAIT_SYNC : ssc_pkg::SSC_RUN;
    else
    begin
      case (state)
        // [RQ9] wait for line sync
        ssc_pkg::SSC_WAIT_SYNC:
          if (ls_pulse)
            state <= ssc_pkg::SSC_RUN;
        default:
          state <= state;
      endcase
    end
  end

  assign spread_active = (state == ssc_pkg::SSC_RUN);

  // free-running base counter keeps tick spacing exact at every rate
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      tick_cnt <= 6'h00;
    else
      tick_cnt <= tick_cnt + 6'h01;
  end

  // [RQ1] rate multiplier, reserved code runs at 1x
  always_comb
  begin
    case (run_cfg.rate)
      ssc_pkg::RATE_2X: tick_mask = 6'(ssc_pkg::MOD_STEP_CYC / 2 - 1);
      ssc_pkg::RATE_4X: tick_mask = 6'(ssc_pkg::MOD_STEP_CYC / 4 - 1);
      default:          tick_mask = 6'(ssc_pkg::MOD_STEP_CYC - 1);
    endcase
  end

  assign step_tick = (tick_cnt & tick_mask) == tick_mask;

  // [RQ6] width and [RQ7] gain set the peak
  assign amp  = width_amp(run_cfg.width, run_cfg.gain);
  // [RQ3] 1/28 step, [RQ4] 1/56 step
  assign step = run_cfg.boost ? ssc_pkg::STEP_BOOST : ssc_pkg::STEP_NORMAL;

  always_comb
  begin
    if (dir_down)
      next_offset = div_offset - step;
    else
      next_offset = div_offset + step;
  end

  // triangle sweep centred on zero offset
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      div_offset <= 8'h00;
      dir_down   <= 1'b0;
    end
    else if (!spread_active || reload)
    begin
      div_offset <= 8'h00;
      dir_down   <= 1'b0;
    end
    else if (step_tick)
    begin
      div_offset <= next_offset;
      if ($signed(next_offset) >= $signed(amp))
        dir_down <= 1'b1;
      else if ($signed(next_offset) <= -$signed(amp))
        dir_down <= 1'b0;
    end
  end

  // ==========================================================
  // checks
  // ==========================================================
  // stored enable rise must always come with a reload
  a_enable_edge_load: assert property ( // [RQ12]
    @(posedge sys_clk) disable iff (!rstn) $rose(cfg.enable) |-> reload)
    else $error("enable edge did not reload");
  a_unsynced_start: assert property ( // [RQ8]
    @(posedge sys_clk) disable iff (!rstn)
    reload && cfg.enable && !cfg.sync |=> spread_active)
    else $error("unsynced spread did not start");
  a_sync_hold: assert property ( // [RQ9]
    @(posedge sys_clk) disable iff (!rstn)
    state == ssc_pkg::SSC_WAIT_SYNC && !ls_pulse && !reload
    |=> !spread_active)
    else $error("spread began before line sync");
  a_sync_start: assert property ( // [RQ9]
    @(posedge sys_clk) disable iff (!rstn)
    state == ssc_pkg::SSC_WAIT_SYNC && ls_pulse && cfg.enable && !reload
    |=> spread_active)
    else $error("spread missed line sync");
  a_normal_step: assert property ( // [RQ3]
    @(posedge sys_clk) disable iff (!rstn)
    spread_active && $past(spread_active) && !run_cfg.boost && !$past(reload)
    |-> 8'(div_offset - $past(div_offset)) inside {8'h00, 8'h02, 8'hfe})
    else $error("normal step not two units");
  a_boost_step: assert property ( // [RQ4]
    @(posedge sys_clk) disable iff (!rstn)
    spread_active && $past(spread_active) && run_cfg.boost && !$past(reload)
    |-> 8'(div_offset - $past(div_offset)) inside {8'h00, 8'h01, 8'hff})
    else $error("boost step not one unit");
  a_peak_bound: assert property ( // [RQ6]
    @(posedge sys_clk) disable iff (!rstn)
    spread_active |-> $signed(div_offset) <= $signed(amp) &&
                      $signed(div_offset) >= -$signed(amp))
    else $error("offset beyond spread width");
  a_gain_double: assert property ( // [RQ7]
    @(posedge sys_clk) disable iff (!rstn)
    run_cfg.gain && run_cfg.width == 2'b00 |-> amp == 8'h20)
    else $error("gain did not double width");
  a_rate_four: assert property ( // [RQ1]
    @(posedge sys_clk) disable iff (!rstn)
    step_tick && run_cfg.rate == ssc_pkg::RATE_4X
    |-> ##16 (step_tick || run_cfg.rate != ssc_pkg::RATE_4X))
    else $error("4x rate tick spacing wrong");
  a_shadow_hold: assert property ( // [RQ13]
    @(posedge sys_clk) disable iff (!rstn)
    !reload |=> $stable(run_cfg))
    else $error("settings changed mid sweep");

  c_sync_run: cover property (@(posedge sys_clk) disable iff (!rstn)
    state == ssc_pkg::SSC_WAIT_SYNC ##1 spread_active);
  c_boost_peak: cover property (@(posedge sys_clk) disable iff (!rstn)
    spread_active && run_cfg.boost && div_offset == amp);
  c_cmd_reload: cover property (@(posedge sys_clk) disable iff (!rstn)
    spread_active && reload);

endmodule

// ==== test/ssc_spread_ctrl_test.sv ====
// Purpose: self-checking bench for the spread clock control block
// Assumes: register byte address is four times the register index
// Notes:   sweep is compared with a bench model of the triangle
`timescale 1ns/100ps
module ssc_spread_ctrl_test;
  // ==========================================================
  // signals
  // ==========================================================
  logic        sys_clk, rstn, line_sync_interval;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, div_offset;
  logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready, spread_active;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid;
  logic [31:0] s_axi_wdata, s_axi_rdata, rnd;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, loop_pump_current, rs;
  logic [2:0]  loop_filter_bw;
  int          err_total, cmp_count, ctrl1_m, ctrl2_m;

  ssc_spread_ctrl DUT (
    .sys_clk, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .line_sync_interval,
    .loop_pump_current, .loop_filter_bw, .spread_active, .div_offset
  );

  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // ==========================================================
  // checking and bus tasks
  // ==========================================================
  task automatic conclude();
    $display("errors %0d checks %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, got);
    cmp_count++;
    if (got !== exp)
    begin
      $display("mismatch %s expected %h seen %h", nm, exp, got);
      err_total++;
    end
  endtask

  task automatic tmo(input int k);
    if (k >= 40)
    begin
      chk("timeout", 0, 1);
      conclude();
    end
  endtask

  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction

  task automatic wr(input logic [7:0] a, d, input logic [3:0] s);
    int  k;
    logic aw_d, w_d;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    aw_d = 1'b0;
    w_d = 1'b0;
    k = 0;
    while (!(aw_d && w_d) && k < 40)
    begin
      @(posedge sys_clk);
      k++;
      if (!aw_d && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (!w_d && s_axi_wready) s_axi_wvalid <= 1'b0;
      aw_d |= s_axi_awready;
      w_d |= s_axi_wready;
    end
    do @(posedge sys_clk); while (!s_axi_bvalid && ++k < 40);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
    tmo(k);
    if (s[0] && a == 8'h64) ctrl2_m = d & 8'h1f;
    if (s[0] && a == 8'h68) ctrl1_m = d;
    chk("bresp", a inside {8'h64, 8'h68, 8'h6c} ? 2'b00 : 2'b10, rs);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    int k;
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    k = 0;
    do @(posedge sys_clk); while (!s_axi_arready && ++k < 40);
    s_axi_arvalid <= 1'b0;
    do @(posedge sys_clk); while (!s_axi_rvalid && ++k < 40);
    d = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
    tmo(k);
  endtask

  task automatic rchk(input logic [7:0] a);
    logic [31:0] d;
    rd(a, d);
    chk("rdata", a == 8'h64 ? ctrl2_m : a == 8'h68 ? ctrl1_m : 0, d);
    chk("rresp", a inside {8'h64, 8'h68, 8'h6c} ? 2'b00 : 2'b10, rs);
  endtask

  // watch the triangle; fresh means it must start at zero going up
  task automatic sweep(input int amp, step, per, input bit fresh);
    int k, v, pv, hi, lo, bad;
    int tq[$];
    k = 0;
    while (spread_active !== 1'b1 && k < 8)
    begin
      @(posedge sys_clk);
      k++;
    end
    chk("start", 1, spread_active);
    if (spread_active !== 1'b1) tmo(40);
    pv = fresh ? 0 : $signed(div_offset);
    hi = pv;
    lo = pv;
    bad = 0;
    for (k = 0; k < (4 * amp / step + 2) * per; k++)
    begin
      @(posedge sys_clk);
      v = $signed(div_offset);
      if ($isunknown(div_offset) || spread_active !== 1'b1) bad++;
      if (v != pv)
      begin
        if (v - pv != step && pv - v != step) bad++;
        if (fresh && tq.size() == 0 && v != step) bad++;
        tq.push_back(k);
        if (tq.size() > 1 && tq[$] - tq[$-1] != per) bad++;
      end
      hi = v > hi ? v : hi;
      lo = v < lo ? v : lo;
      pv = v;
    end
    chk("peak", amp, hi);
    chk("trough", -amp, lo);
    chk("sweep", 0, bad);
  endtask

  task automatic stop();
    wr(8'h68, 8'h00, 4'h1);
    repeat (2) @(posedge sys_clk);
    chk("idle", 0, spread_active);
    chk("offset", 0, div_offset);
  endtask

  task automatic spin(input logic [7:0] c);
    wr(8'h68, c, 4'h1);
    sweep((16 >> c[3:2]) << c[4], c[5] ? 1 : 2,
          c[7:6] == 2'b01 ? 32 : c[7:6] == 2'b10 ? 16 : 64, 1);
    stop();
  endtask

  // ==========================================================
  // main sequence
  // ==========================================================
  initial
  begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, line_sync_interval} = '0;
    {err_total, cmp_count, ctrl1_m} = '0;
    ctrl2_m = 8'h18;
    rnd = 32'h0000_0052;
    rstn = 1'b0;
    repeat (10) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    chk("pump", 2'b11, loop_pump_current);
    chk("filter", 3'b000, loop_filter_bw);
    rchk(8'h64);
    rchk(8'h68);
    rchk(8'h40);
    wr(8'h40, 8'hff, 4'h1);
    wr(8'h64, 8'hff, 4'h1);
    rchk(8'h64);
    // software prepares the loop before spreading
    wr(8'h64, 8'h07, 4'h1);
    @(posedge sys_clk);
    chk("pump", 2'b00, loop_pump_current);
    chk("filter", 3'b111, loop_filter_bw);
    wr(8'h68, 8'hff, 4'h0);
    rchk(8'h68);
    chk("idle", 0, spread_active);
    for (int r = 0; r < 4; r++) spin({r[1:0], 6'b00_1101});
    // 4x runs: no line length above 32,768 is ever programmed
    for (int w = 0; w < 4; w++) spin({4'b1001, w[1:0], 2'b01});
    // boost run 8'ha9 assumes a pixel clock of 25 MHz or less; 8'h8d has boost clear
    spin(8'ha9);
    spin(8'h8d);
    repeat (5)
    begin
      rnd = xs(rnd);
      spin((rnd[7:0] & 8'hfd) | 8'h01);
    end
    wr(8'h68, 8'h8d, 4'h1);
    sweep(2, 2, 16, 1);
    wr(8'h68, 8'h89, 4'h1);
    sweep(2, 2, 16, 0);
    wr(8'h6c, 8'h80, 4'h1);
    rchk(8'h6c);
    sweep(4, 2, 16, 0);
    stop();
    wr(8'h68, 8'h8f, 4'h1);
    repeat (30) @(posedge sys_clk);
    chk("held", 0, spread_active);
    rd(8'h74, rnd);
    chk("waiting", 2'b10, rnd[1:0]);
    line_sync_interval <= 1'b1;
    repeat (3) @(posedge sys_clk);
    line_sync_interval <= 1'b0;
    sweep(2, 2, 16, 1);
    stop();
    conclude();
  end
endmodule
